// *** rtl/asfb_top.sv ***
// asfb_top.sv: register file, character format, baud generator, transmitter
// and receiver of an asynchronous serial element.
// assumes: all inputs synchronous to CLK; modem inputs active low.
// Contract
// - line format bit 7 set maps offsets 0 and 1 to divisor bytes.
// - with bit 7 clear, offset 0 is data and offset 1 enables.
// - offset 0 read gives received char, write loads transmit holding.
// - serial bits go least significant first both ways.
// - low two format bits pick 5, 6, 7 or 8 data bits.
// - stop select clear gives one stop bit sent and checked.
// - stop select set gives 1.5 stops for 5 bits, else two.
// - parity on inserts parity after data and checks it on receive.
// - even select clear means odd parity, set means even.
// - stick parity sends and checks constant, inverse of even select.
// - break control forces serial out low until cleared, outside loopback.
// - baud generator divides clock by divisor to a 16x tick.
// - divisor held as two bytes, low bits 0-7, high bits 8-15.
// - writing either divisor byte reloads the baud counter at once.
// - interrupt enables are four bits, bits 4 to 7 read zero.
// - identification bit 0 low when pending, code in bits 1-2.
// - modem control holds dtr, rts, out1, out2, loop; rest zero.
// - line status bits 0-6 report receive and transmit state.
// - modem status gives change flags low, current levels high.
// - data ready set on char arrival, cleared by read or zero write.
// - overrun, parity, framing and break clear on status read.
// - interrupts ranked line status, data, holding empty, modem.
// - reset clears line status except holding and shifter empty set.
`timescale 1ns/1ps
`default_nettype none
`include "asfb_map.svh"
module asfb_top (
  input  wire logic       CLK,
  input  wire logic       ARST_N,
  input  wire logic [2:0] ADDR,
  input  wire logic       RD,
  input  wire logic       WR,
  input  wire logic [7:0] WDATA,
  output logic      [7:0] RDATA,
  input  wire logic       SERIAL_IN,
  output logic            SERIAL_OUT,
  output logic            BAUD_TICK,
  input  wire logic       CTS_N,
  input  wire logic       DSR_N,
  input  wire logic       RI_N,
  input  wire logic       DCD_N,
  output logic            DTR_N,
  output logic            RTS_N,
  output logic            OUT1_N,
  output logic            OUT2_N,
  output logic            INTR,
  input  wire logic       TX_VALID,
  output logic            TX_READY,
  input  wire logic [7:0] TX_DATA
);
  // register state
  logic [7:0]  lfc_ff, nxt_lfc;
  logic [3:0]  ien_ff, nxt_ien;
  logic [4:0]  mlc_ff, nxt_mlc;
  logic [15:0] div_ff, nxt_div;
  logic [15:0] bcnt_ff, nxt_bcnt;
  logic [7:0]  thr_ff, nxt_thr, rbr_ff, nxt_rbr;
  logic        dr_ff, oe_ff, pe_ff, fe_ff, bi_ff, the_ff;
  logic        nxt_dr, nxt_oe, nxt_pe, nxt_fe, nxt_bi, nxt_the;
  logic [3:0]  mdelta_ff, nxt_mdelta, mlev_ff;
  logic        holding_empty_irq_ff, nxt_holding_empty_irq;
  logic [7:0]  rdata_ff, nxt_rdata;
  asfb_pkg::asfb_fmt_t fmt;
  logic        divisor_access_select, loop, tick, sin_i;
  logic [3:0]  mnow;
  logic        wr_thr;
  logic [7:0]  iid, rx_data;
  logic        fifo_in_rdy, tx_load, tshift_empty;

  // tx / rx engine state
  asfb_pkg::asfb_state_t ts_ff, nxt_ts, rs_ff, nxt_rs;
  logic [7:0]  tsr_ff, nxt_tsr, rsr_ff, nxt_rsr;
  logic [3:0]  tsub_ff, nxt_tsub, rsub_ff, nxt_rsub;
  logic [2:0]  tbit_ff, nxt_tbit, rbit_ff, nxt_rbit;
  logic        tpar_ff, nxt_tpar, rpar_ff, nxt_rpar;
  logic        tstop_ff, nxt_tstop, tout_ff, nxt_tout;
  logic        rzero_ff, nxt_rzero, sin_q_ff;
  logic        rx_push, rx_perr, rx_ferr, rx_brk;
  asfb_pkg::asfb_rxw_t rx_w, fifo_q;
  logic        fifo_v, fifo_pop;

  // number of data bits minus one, from the length code
  function automatic logic [2:0] last_bit(input logic [1:0] len);
    return {1'b1, len} - 3'h4 + 3'h4;
  endfunction

  // parity bit to send or expect for given data under the format
  function automatic logic par_bit(input logic [7:0] d,
                                   input asfb_pkg::asfb_fmt_t f);
    logic [7:0] m;
    m = 8'h1f;
    case (f.len)
      2'h1:    m = 8'h3f;
      2'h2:    m = 8'h7f;
      2'h3:    m = 8'hff;
      default: m = 8'h1f;
    endcase
    if (f.stick) return !f.even;
    return ^(d & m) ^ !f.even;
  endfunction

  always_comb begin
    divisor_access_select  = lfc_ff[`ASFB_LFC_DIVISOR_ACCESS_SELECT];
    loop  = mlc_ff[`ASFB_MLC_LOOP];
    fmt   = '{len: lfc_ff[1:0], stop2: lfc_ff[`ASFB_LFC_STOP],
              par_on: lfc_ff[`ASFB_LFC_PAR], even: lfc_ff[`ASFB_LFC_EVEN],
              stick: lfc_ff[`ASFB_LFC_STICK]};
    // loopback turns tx back into rx and modem outputs into inputs
    sin_i = loop ? tout_ff : SERIAL_IN;
    mnow  = loop ? {mlc_ff[3], mlc_ff[2], mlc_ff[0], mlc_ff[1]}
                 : {!DCD_N, !RI_N, !DSR_N, !CTS_N};
    wr_thr = WR && ADDR == `ASFB_OFF_DATA && !divisor_access_select;
  end

  // baud generator: counter reloads from divisor, tick on wrap
  always_comb begin
    tick     = (bcnt_ff <= 16'h0001) && div_ff != 16'h0000;
    nxt_bcnt = tick ? div_ff : bcnt_ff - 16'h0001;
    if (bcnt_ff == 16'h0000) nxt_bcnt = div_ff;
    if (WR && divisor_access_select && ADDR <= `ASFB_OFF_IEN) begin
      nxt_bcnt = (ADDR == `ASFB_OFF_DATA) ? {div_ff[15:8], WDATA}
                                         : {WDATA, div_ff[7:0]};
    end
  end

  // register writes and status flags
  always_comb begin
    nxt_lfc = lfc_ff; nxt_ien = ien_ff; nxt_mlc = mlc_ff; nxt_div = div_ff;
    nxt_thr = thr_ff; nxt_rbr = rbr_ff;
    nxt_dr = dr_ff; nxt_oe = oe_ff; nxt_pe = pe_ff; nxt_fe = fe_ff;
    nxt_bi = bi_ff; nxt_the = the_ff; nxt_holding_empty_irq = holding_empty_irq_ff;
    nxt_mdelta = mdelta_ff;
    fifo_pop = 1'b0;
    if (WR) begin
      case (ADDR)
        `ASFB_OFF_DATA: if (divisor_access_select) nxt_div[7:0] = WDATA;
                        else begin nxt_thr = WDATA; nxt_the = 1'b0; end
        `ASFB_OFF_IEN:  if (divisor_access_select) nxt_div[15:8] = WDATA;
                        else nxt_ien = WDATA[3:0];
        `ASFB_OFF_LFC:  nxt_lfc = WDATA;
        `ASFB_OFF_MLC:  nxt_mlc = WDATA[4:0];
        `ASFB_OFF_LST:  if (!WDATA[0]) nxt_dr = 1'b0;
        default: ;
      endcase
    end
    if (wr_thr) nxt_holding_empty_irq = 1'b0;
    // enabling the empty interrupt while already empty raises it at once,
    // otherwise a host that enables late would wait for a character forever
    if (WR && !divisor_access_select && ADDR == `ASFB_OFF_IEN && WDATA[1] && !ien_ff[1]
        && the_ff) begin
      nxt_holding_empty_irq = 1'b1;
    end
    if (RD && ADDR == `ASFB_OFF_DATA && !divisor_access_select) nxt_dr = 1'b0;
    if (RD && ADDR == `ASFB_OFF_LST) begin
      nxt_oe = 1'b0; nxt_pe = 1'b0; nxt_fe = 1'b0; nxt_bi = 1'b0;
    end
    if (RD && ADDR == `ASFB_OFF_IID && iid[2:1] == 2'h1) nxt_holding_empty_irq = 1'b0;
    if (RD && ADDR == `ASFB_OFF_MLS) nxt_mdelta = 4'h0;
    // hardware sets win over clears in the same cycle
    nxt_mdelta = nxt_mdelta | {mlev_ff[3] ^ mnow[3],
                               mlev_ff[2] & !mnow[2],
                               mlev_ff[1:0] ^ mnow[1:0]};
    // next character moves into the buffer once the old one is taken
    if (fifo_v && !nxt_dr) begin
      fifo_pop = 1'b1;
      nxt_rbr  = fifo_q.data;
      nxt_dr   = 1'b1;
      nxt_pe   = nxt_pe | fifo_q.perr;
      nxt_fe   = nxt_fe | fifo_q.ferr;
      nxt_bi   = nxt_bi | fifo_q.brk;
    end
    if (rx_push && !fifo_in_rdy) nxt_oe = 1'b1;
    if (tx_load) begin
      nxt_the = 1'b1;
      nxt_holding_empty_irq = 1'b1;
    end
  end

  // interrupt identification, lowest source first, later checks override
  always_comb begin
    iid = `ASFB_IID_NONE;
    if (ien_ff[3] && mdelta_ff != 4'h0)        iid = 8'h00;
    if (ien_ff[1] && the_ff && holding_empty_irq_ff)    iid = 8'h02;
    if (ien_ff[0] && dr_ff)                    iid = 8'h04;
    if (ien_ff[2] && (oe_ff | pe_ff | fe_ff | bi_ff)) iid = 8'h06;
    INTR = !iid[0];
  end

  // read mux; unmapped offset reads zero
  always_comb begin
    case (ADDR)
      `ASFB_OFF_DATA: nxt_rdata = divisor_access_select ? div_ff[7:0] : rbr_ff;
      `ASFB_OFF_IEN:  nxt_rdata = divisor_access_select ? div_ff[15:8] : {4'h0, ien_ff};
      `ASFB_OFF_IID:  nxt_rdata = iid;
      `ASFB_OFF_LFC:  nxt_rdata = lfc_ff;
      `ASFB_OFF_MLC:  nxt_rdata = {3'h0, mlc_ff};
      `ASFB_OFF_LST:  nxt_rdata = {1'b0, tshift_empty, the_ff, bi_ff, fe_ff,
                                   pe_ff, oe_ff, dr_ff};
      `ASFB_OFF_MLS:  nxt_rdata = {mnow, mdelta_ff};
      default:        nxt_rdata = 8'h00;
    endcase
  end

  // transmitter: holding register feeds shifter; TX_DATA handshake word feeds holding
  always_comb begin
    tshift_empty = (ts_ff == asfb_pkg::ASFB_IDLE);
    TX_READY = the_ff && !wr_thr && !tx_load;
    tx_load  = !the_ff && tshift_empty;
    nxt_ts = ts_ff; nxt_tsr = tsr_ff; nxt_tsub = tsub_ff; nxt_tbit = tbit_ff;
    nxt_tpar = tpar_ff; nxt_tstop = tstop_ff; nxt_tout = tout_ff;
    if (tx_load) begin
      nxt_ts = asfb_pkg::ASFB_START; nxt_tsr = thr_ff; nxt_tsub = 4'h0;
      nxt_tout = 1'b0; nxt_tpar = par_bit(thr_ff, fmt);
    end else if (tick) begin
      nxt_tsub = tsub_ff + 4'h1;
      if (tsub_ff == `ASFB_OVS || (ts_ff == asfb_pkg::ASFB_STOP && tstop_ff
          && fmt.len == 2'h0 && tsub_ff == `ASFB_HALF_STOP)) begin
        nxt_tsub = 4'h0;
        case (ts_ff)
          asfb_pkg::ASFB_START: begin
            nxt_ts = asfb_pkg::ASFB_DATA; nxt_tbit = 3'h0;
            nxt_tout = tsr_ff[0];
          end
          asfb_pkg::ASFB_DATA:
            if (tbit_ff == last_bit(fmt.len)) begin
              nxt_ts = fmt.par_on ? asfb_pkg::ASFB_PARITY
                                  : asfb_pkg::ASFB_STOP;
              nxt_tout = fmt.par_on ? tpar_ff : 1'b1;
              nxt_tstop = 1'b0;
            end else begin
              nxt_tbit = tbit_ff + 3'h1;
              nxt_tsr  = tsr_ff >> 1;
              nxt_tout = tsr_ff[1];
            end
          asfb_pkg::ASFB_PARITY: begin
            nxt_ts = asfb_pkg::ASFB_STOP; nxt_tout = 1'b1; nxt_tstop = 1'b0;
          end
          asfb_pkg::ASFB_STOP:
            if (fmt.stop2 && !tstop_ff) nxt_tstop = 1'b1;
            else nxt_ts = asfb_pkg::ASFB_IDLE;
          default: nxt_ts = asfb_pkg::ASFB_IDLE;
        endcase
      end
    end
    SERIAL_OUT = tout_ff && !lfc_ff[`ASFB_LFC_BREAK] || loop;
  end

  // receiver: start edge, mid-cell sampling at half of sixteen ticks
  always_comb begin
    nxt_rs = rs_ff; nxt_rsr = rsr_ff; nxt_rsub = rsub_ff; nxt_rbit = rbit_ff;
    nxt_rpar = rpar_ff; nxt_rzero = rzero_ff;
    rx_push = 1'b0; rx_perr = 1'b0; rx_ferr = 1'b0; rx_brk = 1'b0;
    if (tick) begin
      nxt_rsub = rsub_ff + 4'h1;
      case (rs_ff)
        asfb_pkg::ASFB_IDLE:
          if (!sin_i) begin nxt_rs = asfb_pkg::ASFB_START; nxt_rsub = 4'h1; end
        asfb_pkg::ASFB_START:
          if (rsub_ff == `ASFB_MID) begin
            nxt_rsub = 4'h0;
            nxt_rs = sin_i ? asfb_pkg::ASFB_IDLE : asfb_pkg::ASFB_DATA;
            nxt_rbit = 3'h0; nxt_rsr = 8'h00; nxt_rzero = 1'b1;
          end
        asfb_pkg::ASFB_DATA:
          if (rsub_ff == `ASFB_OVS) begin
            nxt_rsr = {sin_i, rsr_ff[7:1]};
            nxt_rzero = rzero_ff & !sin_i;
            nxt_rbit = rbit_ff + 3'h1;
            if (rbit_ff == last_bit(fmt.len))
              nxt_rs = fmt.par_on ? asfb_pkg::ASFB_PARITY
                                  : asfb_pkg::ASFB_STOP;
          end
        asfb_pkg::ASFB_PARITY:
          if (rsub_ff == `ASFB_OVS) begin
            nxt_rpar = sin_i; nxt_rzero = rzero_ff & !sin_i;
            nxt_rs = asfb_pkg::ASFB_STOP;
          end
        asfb_pkg::ASFB_STOP:
          if (rsub_ff == `ASFB_OVS) begin
            rx_push = 1'b1;
            rx_ferr = !sin_i;
            rx_brk  = rzero_ff && !sin_i;
            rx_perr = fmt.par_on && (rpar_ff != par_bit(rx_data, fmt));
            nxt_rs = asfb_pkg::ASFB_IDLE;
          end
        default: nxt_rs = asfb_pkg::ASFB_IDLE;
      endcase
    end
  end

  // align short characters to bit 0
  always_comb begin
    rx_data = rsr_ff >> (3'h7 - last_bit(fmt.len));
    rx_w    = '{perr: rx_perr, ferr: rx_ferr, brk: rx_brk, data: rx_data};
  end

  asfb_fifo #(.W(11), .D(`ASFB_FIFO_DEPTH)) u_rxq (
    .clk       (CLK),
    .arst_n    (ARST_N),
    .in_valid  (rx_push),
    .in_ready  (fifo_in_rdy),
    .in_data   (rx_w),
    .out_valid (fifo_v),
    .out_ready (fifo_pop),
    .out_data  (fifo_q)
  );

  // all state registers; reset state of line status has both empties set
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      lfc_ff <= `ASFB_LFC_RST; ien_ff <= `ASFB_IEN_RST;
      mlc_ff <= `ASFB_MLC_RST; div_ff <= `ASFB_DIV_RST;
      bcnt_ff <= `ASFB_DIV_RST; thr_ff <= 8'h00; rbr_ff <= 8'h00;
      dr_ff <= 1'b0; oe_ff <= 1'b0; pe_ff <= 1'b0; fe_ff <= 1'b0;
      bi_ff <= 1'b0; the_ff <= 1'b1;
      mdelta_ff <= 4'h0; mlev_ff <= 4'h0; holding_empty_irq_ff <= 1'b0;
      rdata_ff <= 8'h00;
      ts_ff <= asfb_pkg::ASFB_IDLE; rs_ff <= asfb_pkg::ASFB_IDLE;
      tsr_ff <= 8'h00; rsr_ff <= 8'h00; tsub_ff <= 4'h0; rsub_ff <= 4'h0;
      tbit_ff <= 3'h0; rbit_ff <= 3'h0; tpar_ff <= 1'b0; rpar_ff <= 1'b0;
      tstop_ff <= 1'b0; tout_ff <= 1'b1; rzero_ff <= 1'b0; sin_q_ff <= 1'b1;
    end else begin
      lfc_ff <= nxt_lfc; ien_ff <= nxt_ien; mlc_ff <= nxt_mlc;
      div_ff <= nxt_div; bcnt_ff <= nxt_bcnt;
      thr_ff <= (TX_VALID && TX_READY) ? TX_DATA : nxt_thr;
      rbr_ff <= nxt_rbr;
      dr_ff <= nxt_dr; oe_ff <= nxt_oe; pe_ff <= nxt_pe; fe_ff <= nxt_fe;
      bi_ff <= nxt_bi;
      the_ff <= (TX_VALID && TX_READY) ? 1'b0 : nxt_the;
      mdelta_ff <= nxt_mdelta; mlev_ff <= mnow; holding_empty_irq_ff <= nxt_holding_empty_irq;
      rdata_ff <= nxt_rdata;
      ts_ff <= nxt_ts; rs_ff <= nxt_rs; tsr_ff <= nxt_tsr; rsr_ff <= nxt_rsr;
      tsub_ff <= nxt_tsub; rsub_ff <= nxt_rsub; tbit_ff <= nxt_tbit;
      rbit_ff <= nxt_rbit; tpar_ff <= nxt_tpar; rpar_ff <= nxt_rpar;
      tstop_ff <= nxt_tstop; tout_ff <= nxt_tout; rzero_ff <= nxt_rzero;
      sin_q_ff <= sin_i;
    end
  end

  // modem outputs are forced inactive in loopback
  always_comb begin
    RDATA     = rdata_ff;
    BAUD_TICK = tick;
    DTR_N  = !(mlc_ff[0] && !loop);
    RTS_N  = !(mlc_ff[1] && !loop);
    OUT1_N = !(mlc_ff[2] && !loop);
    OUT2_N = !(mlc_ff[3] && !loop);
  end

  AST_BREAK_LOW: assert property (@(posedge CLK) disable iff (!ARST_N)
    lfc_ff[`ASFB_LFC_BREAK] && !loop |-> !SERIAL_OUT)
    else $error("break does not hold line low");
  AST_DIV_RELOAD: assert property (@(posedge CLK) disable iff (!ARST_N)
    WR && divisor_access_select && ADDR == `ASFB_OFF_DATA |=> bcnt_ff[7:0] == $past(WDATA))
    else $error("baud counter not reloaded");
  AST_DIVISOR_ACCESS_SELECT_LOW: assert property (@(posedge CLK) disable iff (!ARST_N)
    WR && divisor_access_select && ADDR == `ASFB_OFF_DATA |=> div_ff[7:0] == $past(WDATA))
    else $error("divisor low byte not written");
  AST_IEN_WR: assert property (@(posedge CLK) disable iff (!ARST_N)
    WR && !divisor_access_select && ADDR == `ASFB_OFF_IEN |=> ien_ff == $past(WDATA[3:0]))
    else $error("enable register not written");
  AST_IID_ZERO: assert property (@(posedge CLK) disable iff (!ARST_N)
    iid[7:3] == 5'h00 && (iid[0] == !INTR))
    else $error("identification upper bits nonzero");
  AST_LST_CLR: assert property (@(posedge CLK) disable iff (!ARST_N)
    RD && ADDR == `ASFB_OFF_LST && !rx_push && !fifo_pop |=> !oe_ff && !pe_ff)
    else $error("error flags survive status read");
  AST_PRIO: assert property (@(posedge CLK) disable iff (!ARST_N)
    ien_ff[2] && oe_ff |-> iid == 8'h06)
    else $error("line status not highest");
  AST_DR_SET: assert property (@(posedge CLK) disable iff (!ARST_N)
    fifo_pop |=> dr_ff)
    else $error("data ready not set");
  AST_THE_CLR: assert property (@(posedge CLK) disable iff (!ARST_N)
    wr_thr |=> !the_ff)
    else $error("holding empty not cleared");
  C_TX: cover property (@(posedge CLK) tx_load);
  C_RX: cover property (@(posedge CLK) fifo_pop);
  C_BRK: cover property (@(posedge CLK) rx_brk && rx_push);
endmodule : asfb_top
`default_nettype wire

// *** rtl/asfb_map.svh ***
// asfb_map.svh: register offsets, field positions and reset values of the
// serial line format and baud block.
// assumes: included by its bare name from the design files under rtl/.
`ifndef ASFB_MAP_SVH
`define ASFB_MAP_SVH

`define ASFB_OFF_DATA     3'h0
`define ASFB_OFF_IEN      3'h1
`define ASFB_OFF_IID      3'h2
`define ASFB_OFF_LFC      3'h3
`define ASFB_OFF_MLC      3'h4
`define ASFB_OFF_LST      3'h5
`define ASFB_OFF_MLS      3'h6

`define ASFB_LFC_DIVISOR_ACCESS_SELECT     7
`define ASFB_LFC_BREAK    6
`define ASFB_LFC_STICK    5
`define ASFB_LFC_EVEN     4
`define ASFB_LFC_PAR      3
`define ASFB_LFC_STOP     2
`define ASFB_MLC_LOOP     4

`define ASFB_LFC_RST      8'h00
`define ASFB_IEN_RST      4'h0
`define ASFB_MLC_RST      5'h00
`define ASFB_DIV_RST      16'h0000
`define ASFB_IID_NONE     8'h01

`define ASFB_OVS          4'hf
`define ASFB_MID          4'h7
`define ASFB_HALF_STOP    4'h7
`define ASFB_FIFO_DEPTH   16

`endif

// *** rtl/asfb_pkg.sv ***
// asfb_pkg.sv: types shared by the serial line format and baud block.
// assumes: nothing beyond a SystemVerilog compiler.
package asfb_pkg;
  // character format as decoded from the line format control register
  typedef struct packed {
    logic [1:0] len;
    logic       stop2;
    logic       par_on;
    logic       even;
    logic       stick;
  } asfb_fmt_t;

  // one received character with its error marks
  typedef struct packed {
    logic       perr;
    logic       ferr;
    logic       brk;
    logic [7:0] data;
  } asfb_rxw_t;

  typedef enum logic [2:0] {
    ASFB_IDLE, ASFB_START, ASFB_DATA, ASFB_PARITY, ASFB_STOP
  } asfb_state_t;
endpackage : asfb_pkg

// *** rtl/asfb_fifo.sv ***
// asfb_fifo.sv: small synchronous fifo, registered read data.
// assumes: one clock, asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module asfb_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem [D];
  logic [AW:0]   wp_ff, rp_ff, nxt_wp, nxt_rp;
  logic [W-1:0]  out_ff, nxt_out;
  logic          ov_ff, nxt_ov;
  logic          empty, full, pop, push;

  // pointers carry a wrap bit so full and empty are exact
  always_comb begin
    empty    = (wp_ff == rp_ff);
    full     = (wp_ff[AW] != rp_ff[AW]) && (wp_ff[AW-1:0] == rp_ff[AW-1:0]);
    in_ready = !full;
    push     = in_valid && !full;
    pop      = !empty && (!ov_ff || out_ready);
    nxt_wp   = push ? wp_ff + 1'b1 : wp_ff;
    nxt_rp   = pop ? rp_ff + 1'b1 : rp_ff;
    nxt_out  = pop ? mem[rp_ff[AW-1:0]] : out_ff;
    nxt_ov   = pop ? 1'b1 : (out_ready ? 1'b0 : ov_ff);
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_ff[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wp_ff  <= '0;
      rp_ff  <= '0;
      out_ff <= '0;
      ov_ff  <= 1'b0;
    end else begin
      wp_ff  <= nxt_wp;
      rp_ff  <= nxt_rp;
      out_ff <= nxt_out;
      ov_ff  <= nxt_ov;
    end
  end

  assign out_valid = ov_ff;
  assign out_data  = out_ff;
endmodule : asfb_fifo
`default_nettype wire

// *** dv/asfb_peer.sv ***
// asfb_peer.sv: far-side serial model; sends 8N1 frames, captures frames.
// assumes: one bit cell lasts BITC clock cycles; line idles high.
`timescale 1ns/1ps
`default_nettype none
module asfb_peer #(
  parameter int BITC = 32
) (
  input  wire logic       clk,
  input  wire logic       serial_out,
  output logic            sin,
  output logic [9:0]      got,
  output int              n
);
  // line rests at mark until a frame is sent
  initial begin
    sin = 1'b1;
    n   = 0;
    got = 10'h000;
  end

  // start cell, eight data cells lsb first, one stop cell
  task send(input logic [7:0] b);
    @(posedge clk) sin <= 1'b0;
    repeat (BITC) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      sin <= b[i];
      repeat (BITC) @(posedge clk);
    end
    sin <= 1'b1;
    repeat (BITC) @(posedge clk);
  endtask : send

  // ten cells after each start cell, sampled mid cell; trailing idle
  // cells read as mark, so short frames still fill the capture
  always begin
    @(negedge serial_out);
    repeat (BITC / 2) @(posedge clk);
    for (int i = 0; i < 10; i++) begin
      repeat (BITC) @(posedge clk);
      got[i] = serial_out;
    end
    n = n + 1;
  end
endmodule : asfb_peer
`default_nettype wire

// *** dv/tb_top.sv ***
// tb_top.sv: self-checking bench for the serial line format and baud block.
// assumes: asfb_peer on the serial lines; divisor 2 gives 32-clock cells.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int BITC = 32;
  logic        clk, arst_n, rd, wr, cts_n, dsr_n, serial_out, sin, tick;
  logic [2:0]  addr;
  logic [7:0]  wdata, rdata, q, k;
  logic [9:0]  got;
  logic [19:0] regs [22];
  logic [27:0] fr   [6];
  int          fail_count, compares, cyc, nfr, n0;

  asfb_top uut (.CLK(clk), .ARST_N(arst_n), .ADDR(addr), .RD(rd), .WR(wr),
    .WDATA(wdata), .RDATA(rdata), .SERIAL_IN(sin), .SERIAL_OUT(serial_out),
    .BAUD_TICK(tick), .CTS_N(cts_n), .DSR_N(dsr_n), .RI_N(1'b1),
    .DCD_N(1'b1), .DTR_N(), .RTS_N(), .OUT1_N(), .OUT2_N(), .INTR(),
    .TX_VALID(1'b0), .TX_READY(), .TX_DATA(8'h00));
  asfb_peer #(.BITC(BITC)) p (.clk(clk), .serial_out(serial_out), .sin(sin),
    .got(got), .n(nfr));

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task chk(input logic [9:0] g, input logic [9:0] e, input string m);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %0t %s got %h want %h", $time, m, g, e);
    end
  endtask : chk

  // strobes change at the falling edge and last one cycle
  task wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(negedge clk) begin addr = a; wdata = d; wr = 1'b1; end
    @(negedge clk) wr = 1'b0;
  endtask : wr_reg

  // read data is registered, so it is settled at the next falling edge
  task rd_reg(input logic [2:0] a, output logic [7:0] d);
    @(negedge clk) begin addr = a; rd = 1'b1; end
    @(negedge clk) rd = 1'b0;
    d = rdata;
  endtask : rd_reg

  task finish_test;
    $display("counts: %0d compares, %0d mismatches", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : finish_test

  // hang guard, far above the few thousand cycles the tests need
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      $display("[ERR] %0t timeout", $time);
      finish_test();
    end
  end

  initial begin
    {arst_n, rd, wr, addr, wdata, cts_n} = {1'b0, 1'b0, 1'b0, 3'h0, 8'h00, 1'b1};
    {fail_count, compares, cyc} = {32'd0, 32'd0, 32'd0};
    dsr_n = 1'b1;
    // {write, offset} nibble, write data, expected read data
    regs = '{20'h50060, 20'h20001, 20'h60011, 20'h60010, 20'h90200,
             20'h20002, 20'h10002, 20'h9ff00, 20'h1000f, 20'h90000,
             20'hc0300, 20'h40003, 20'hc0000, 20'hb8000, 20'h80200,
             20'h90000, 20'h00002, 20'h10000, 20'hb0300, 20'h30003,
             20'haff00, 20'h20001};
    // line format, character, ten captured cells after the start
    fr = '{28'h03a53a5, 28'h1a53353, 28'h0a533d3, 28'h28163f6,
           28'h38163d6, 28'h013c3fc};
    repeat (12) @(posedge clk);
    @(negedge clk) arst_n = 1'b1;
    @(negedge clk) cts_n = 1'b0;
    repeat (2) @(negedge clk);
    foreach (regs[i]) begin
      if (regs[i][19])
        wr_reg(regs[i][18:16], regs[i][15:8]);
      else begin
        rd_reg(regs[i][18:16], q);
        chk(q, regs[i][7:0], "register");
      end
    end
    $display("test registers done");
    k = 8'h00;
    repeat (64) @(negedge clk) if (tick === 1'b1) k++;
    chk(k, 8'h20, "tick count");
    $display("test baud done");
    foreach (fr[i]) begin
      wr_reg(3'h3, fr[i][27:20]);
      n0 = nfr;
      wr_reg(3'h0, fr[i][19:12]);
      for (int t = 0; t < 800 && nfr == n0; t++) @(negedge clk);
      chk(got, fr[i][9:0], "frame");
    end
    $display("test transmit done");
    wr_reg(3'h3, 8'h03);
    p.send(8'h3c);
    repeat (40) @(negedge clk);
    rd_reg(3'h5, q);
    chk(q, 8'h61, "status ready");
    rd_reg(3'h0, q);
    chk(q, 8'h3c, "received");
    rd_reg(3'h5, q);
    chk(q, 8'h60, "status cleared");
    @(negedge clk) dsr_n = 1'b0;
    rd_reg(3'h6, q);
    chk(q, 8'h32, "dsr change");
    $display("test receive done");
    wr_reg(3'h3, 8'h43);
    @(negedge clk);
    chk(serial_out, 1'b0, "break low");
    wr_reg(3'h3, 8'h03);
    @(negedge clk);
    chk(serial_out, 1'b1, "break off");
    $display("test break done");
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
